// [lpd_map.svh]
// Command codes, field positions, reset values and timing counts
`ifndef LPD_MAP_SVH
`define LPD_MAP_SVH
`define LPD_CMD_BIAS_PFX 8'hF3
`define LPD_BIAS_SAVE_ON 8'h00
`define LPD_BIAS_SAVE_OFF 8'h04
`define LPD_CMD_BOOST 8'h64
`define LPD_MASK_BOOST 8'hFC
`define LPD_CMD_RRATIO 8'h20
`define LPD_MASK_RRATIO 8'hF8
`define LPD_CMD_CONTRAST 8'h81
`define LPD_CMD_BIAS 8'h50
`define LPD_MASK_BIAS 8'hF8
`define LPD_CMD_COMDIR 8'hC0
`define LPD_MASK_COMDIR 8'hF0
`define LPD_COMDIR_BIT 3
`define LPD_CMD_SEGDIR 8'hA0
`define LPD_MASK_ONEBIT 8'hFE
`define LPD_CMD_OSC_ON 8'hAB
`define LPD_CMD_SLEEP 8'hA8
`define LPD_CMD_WAKE 8'hE1
`define LPD_CMD_SWRESET 8'hE2
`define LPD_CMD_DIRLEN 8'hE8
`define LPD_CMD_NOP 8'hE3
`define LPD_CMD_TEST 8'hF0
`define LPD_MASK_TEST 8'hF0
`define LPD_CMD_FRCPWM 8'h90
`define LPD_MASK_FRCPWM 8'hF8
`define LPD_CMD_GRAY 8'h80
`define LPD_MASK_GRAY 8'hC0
`define LPD_PWM_ILLEGAL 2'h3
`define LPD_PWM_60 2'h2
`define LPD_W45 6'h2D
`define LPD_W60 6'h3C
`define LPD_RST_BOOST 2'h0
`define LPD_RST_RRATIO 3'h0
`define LPD_RST_CONTRAST 6'h20
`define LPD_RST_BIAS 3'h0
`define LPD_BUSY_NS 100
`define LPD_CLK_NS 10
`define LPD_BUSY_CYC ((`LPD_BUSY_NS + `LPD_CLK_NS - 1) / `LPD_CLK_NS)
`endif

// [lpd_pkg.sv]
// Types shared by both ends of the command link
package lpd_pkg;
   typedef enum logic [1:0] {
      LPD_DS_IDLE = 2'b00,
      LPD_DS_PARAM = 2'b01,
      LPD_DS_DATA = 2'b10
   } lpd_dec_state_t;
   typedef enum logic [1:0] {
      LPD_HS_IDLE = 2'b00,
      LPD_HS_SEND = 2'b01,
      LPD_HS_WAIT = 2'b10
   } lpd_host_state_t;
endpackage

// [lpd_if.sv]
// Byte link between host and command decoder
`timescale 1ns/1ps
`default_nettype none
interface lpd_if;
   logic wr_stb;
   logic reg_select;
   logic [7:0] data;
   logic iface_sel0;
   logic iface_sel1;
   logic busy;
   modport dev (input wr_stb, reg_select, data, iface_sel0, iface_sel1,
      output busy);
   modport host (output wr_stb, reg_select, data, iface_sel0, iface_sel1,
      input busy);
endinterface
`default_nettype wire

// [lpd_dev.sv]
// Command decoder of the display controller end
//
// Overview of operation
// - Prefix F3 then 00 enters bias save
// - Prefix F3 then 04 leaves bias save
// - Boost field selects three to six times
// - Resistor field selects gain 2.3 to 7.2
// - Contrast prefix then six-bit level load
// - Bias field selects 1/5 down to 1/12
// - Bit 3 sets common scan direction
// - Bit 0 sets segment mapping direction
// - Oscillator start command enables oscillator
// - Power save bit 1 enters sleep
// - Release command leaves sleep
// - Soft reset restores line, addresses, direction
// - Soft reset keeps power supply settings
// - Length pair only in three-wire mode
// - Length plus one bytes taken as data
// - Host never sends test code
// - Frame modulation bit picks four or three
// - PWM code picks 45 or 60 steps
// - Gray prefix selects level and frame
// - Entry width zero above step count
// - Bytes rejected while busy
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "lpd_map.svh"
module lpd_dev
   import lpd_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   lpd_if.dev lnk,
   output logic o_bias_save,
   output logic [1:0] o_boost_sel,
   output logic [2:0] o_resistor_ratio,
   output logic [5:0] o_contrast_level,
   output logic [2:0] o_bias_ratio,
   output logic o_common_scan_dir,
   output logic o_seg_reverse,
   output logic o_osc_on,
   output logic o_sleep,
   output logic o_soft_reset,
   output logic o_frame_mod_sel,
   output logic [1:0] o_pulse_steps,
   output logic o_data_stb,
   output logic [7:0] o_data,
   output logic o_gray_we,
   output logic [5:0] o_gray_addr,
   output logic [5:0] o_gray_width
);
   lpd_dec_state_t state_reg;
   logic [7:0] prefix_reg;
   logic [8:0] data_left_reg;
   logic [3:0] busy_cnt_reg;
   logic [5:0] gray_store_reg [0:63];
   logic take;
   logic cmd;
   logic [7:0] b;
   logic three_wire;
   logic [5:0] wmax;
   logic dirlen;
   logic gray_clash;
   logic pfx_byte;

   ////////////////////////////////////////////////////////////////////
   assign b = lnk.data;
   assign three_wire = !lnk.iface_sel0 && !lnk.iface_sel1;
   assign lnk.busy = (busy_cnt_reg != 4'h0);
   // Writes landing during busy are dropped, not queued
   assign take = lnk.wr_stb && !lnk.busy;
   // In data-length mode the register-select line is not consulted
   assign cmd = take && !lnk.reg_select && state_reg != LPD_DS_DATA;
   assign wmax = (o_pulse_steps == `LPD_PWM_60) ? `LPD_W60 : `LPD_W45;
   // Length opener ignores register-select in three-wire mode
   assign dirlen = (b == `LPD_CMD_DIRLEN) && three_wire;
   // Gray prefixes share their range with one-byte codes, which win;
   // otherwise a mode byte would swallow the next command as an entry
   assign gray_clash = ((b & `LPD_MASK_ONEBIT) == `LPD_CMD_SEGDIR) ||
      ((b & `LPD_MASK_ONEBIT) == `LPD_CMD_SLEEP) ||
      (b == `LPD_CMD_OSC_ON) || (b == `LPD_CMD_CONTRAST) ||
      ((b & `LPD_MASK_FRCPWM) == `LPD_CMD_FRCPWM);
   assign pfx_byte = dirlen || (!lnk.reg_select &&
      (b == `LPD_CMD_BIAS_PFX || b == `LPD_CMD_CONTRAST ||
      ((b & `LPD_MASK_GRAY) == `LPD_CMD_GRAY && !gray_clash)));

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy_cnt_reg <= 4'h0;
      end else if (take) begin
         busy_cnt_reg <= 4'(`LPD_BUSY_CYC);
      end else if (busy_cnt_reg != 4'h0) begin
         busy_cnt_reg <= busy_cnt_reg - 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer for two-byte commands and the data-length run
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= LPD_DS_IDLE;
         prefix_reg <= 8'h00;
         data_left_reg <= 9'h000;
      end else if (take) begin
         unique case (state_reg)
            LPD_DS_IDLE: begin
               if (pfx_byte) begin
                  state_reg <= LPD_DS_PARAM;
                  prefix_reg <= b;
               end
            end
            LPD_DS_PARAM: begin
               // Second byte pairs with the stored prefix
               if (prefix_reg == `LPD_CMD_DIRLEN) begin
                  state_reg <= LPD_DS_DATA;
                  data_left_reg <= {1'b0, b} + 9'h001;
               end else begin
                  state_reg <= LPD_DS_IDLE;
               end
            end
            LPD_DS_DATA: begin
               if (data_left_reg == 9'h001) begin
                  state_reg <= LPD_DS_IDLE;
               end
               data_left_reg <= data_left_reg - 9'h001;
            end
            default: state_reg <= LPD_DS_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_data_stb <= 1'b0;
         o_data <= 8'h00;
      end else begin
         o_data_stb <= 1'b0;
         if (take && (state_reg == LPD_DS_DATA ||
             (state_reg == LPD_DS_IDLE && lnk.reg_select && !dirlen))) begin
            o_data_stb <= 1'b1;
            o_data <= b;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Power settings: cleared only by the reset pin, never by soft reset
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_bias_save <= 1'b0;
         o_boost_sel <= `LPD_RST_BOOST;
         o_resistor_ratio <= `LPD_RST_RRATIO;
         o_contrast_level <= `LPD_RST_CONTRAST;
         o_bias_ratio <= `LPD_RST_BIAS;
      end else if (cmd && state_reg == LPD_DS_PARAM) begin
         if (prefix_reg == `LPD_CMD_BIAS_PFX && b == `LPD_BIAS_SAVE_ON) begin
            o_bias_save <= 1'b1;
         end else if (prefix_reg == `LPD_CMD_BIAS_PFX &&
                      b == `LPD_BIAS_SAVE_OFF) begin
            o_bias_save <= 1'b0;
         end else if (prefix_reg == `LPD_CMD_CONTRAST) begin
            o_contrast_level <= b[5:0];
         end
      end else if (cmd && state_reg == LPD_DS_IDLE) begin
         if ((b & `LPD_MASK_BOOST) == `LPD_CMD_BOOST) begin
            o_boost_sel <= b[1:0];
         end else if ((b & `LPD_MASK_RRATIO) == `LPD_CMD_RRATIO) begin
            o_resistor_ratio <= b[2:0];
         end else if ((b & `LPD_MASK_BIAS) == `LPD_CMD_BIAS) begin
            o_bias_ratio <= b[2:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Single-byte mode commands; the test code falls through untouched
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_common_scan_dir <= 1'b0;
         o_seg_reverse <= 1'b0;
         o_osc_on <= 1'b0;
         o_sleep <= 1'b0;
         o_soft_reset <= 1'b0;
         o_frame_mod_sel <= 1'b0;
         o_pulse_steps <= 2'h0;
      end else begin
         o_soft_reset <= 1'b0;
         if (cmd && state_reg == LPD_DS_IDLE) begin
            if ((b & `LPD_MASK_COMDIR) == `LPD_CMD_COMDIR) begin
               o_common_scan_dir <= b[`LPD_COMDIR_BIT];
            end else if ((b & `LPD_MASK_ONEBIT) == `LPD_CMD_SEGDIR) begin
               o_seg_reverse <= b[0];
            end else if (b == `LPD_CMD_OSC_ON) begin
               o_osc_on <= 1'b1;
            end else if ((b & `LPD_MASK_ONEBIT) == `LPD_CMD_SLEEP) begin
               o_sleep <= b[0];
            end else if (b == `LPD_CMD_WAKE) begin
               o_sleep <= 1'b0;
            end else if (b == `LPD_CMD_SWRESET) begin
               // Line, addresses and direction; display memory kept
               o_common_scan_dir <= 1'b0;
               o_soft_reset <= 1'b1;
            end else if ((b & `LPD_MASK_FRCPWM) == `LPD_CMD_FRCPWM) begin
               o_frame_mod_sel <= b[2];
               if (b[1:0] != `LPD_PWM_ILLEGAL) begin
                  o_pulse_steps <= b[1:0];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Gray table: index is level then frame; out-of-range gives zero width
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_gray_we <= 1'b0;
         o_gray_addr <= 6'h00;
         o_gray_width <= 6'h00;
      end else begin
         o_gray_we <= 1'b0;
         if (cmd && state_reg == LPD_DS_PARAM &&
             (prefix_reg & `LPD_MASK_GRAY) == `LPD_CMD_GRAY &&
             prefix_reg != `LPD_CMD_CONTRAST) begin
            o_gray_we <= 1'b1;
            o_gray_addr <= prefix_reg[5:0];
            o_gray_width <= (b[5:0] > wmax) ? 6'h00 : b[5:0];
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (o_gray_we) begin
         gray_store_reg[o_gray_addr] <= o_gray_width;
      end
   end
endmodule
`default_nettype wire

// [lpd_host.sv]
// Host end: sends one byte per request and waits out busy
`timescale 1ns/1ps
`default_nettype none
`include "lpd_map.svh"
module lpd_host
   import lpd_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   lpd_if.host lnk,
   input wire logic i_req,
   input wire logic i_reg_select,
   input wire logic [7:0] i_byte,
   input wire logic [1:0] i_iface_sel,
   output logic o_ready
);
   lpd_host_state_t state_reg;
   logic rs_reg;
   logic [7:0] byte_reg;
   logic blocked;

   // Test codes are swallowed here so they never reach the device
   // PWM code 11 is also withheld
   assign blocked = !i_reg_select &&
      ((i_byte & `LPD_MASK_TEST) == `LPD_CMD_TEST) &&
      (i_byte != `LPD_CMD_BIAS_PFX);
   assign o_ready = (state_reg == LPD_HS_IDLE) && !lnk.busy;
   assign lnk.wr_stb = (state_reg == LPD_HS_SEND);
   assign lnk.reg_select = rs_reg;
   assign lnk.data = byte_reg;
   // Length command only legal with both select lines low
   assign lnk.iface_sel0 = i_iface_sel[0];
   assign lnk.iface_sel1 = i_iface_sel[1];

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= LPD_HS_IDLE;
         rs_reg <= 1'b0;
         byte_reg <= 8'h00;
      end else begin
         unique case (state_reg)
            LPD_HS_IDLE: begin
               if (i_req && o_ready && !blocked &&
                   !(!i_reg_select &&
                     (i_byte & `LPD_MASK_FRCPWM) == `LPD_CMD_FRCPWM &&
                     i_byte[1:0] == `LPD_PWM_ILLEGAL)) begin
                  state_reg <= LPD_HS_SEND;
                  rs_reg <= i_reg_select;
                  byte_reg <= i_byte;
               end
            end
            LPD_HS_SEND: state_reg <= LPD_HS_WAIT;
            // Back-to-back pairing is the caller's order of requests
            LPD_HS_WAIT: begin
               if (!lnk.busy) begin
                  state_reg <= LPD_HS_IDLE;
               end
            end
            default: state_reg <= LPD_HS_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// [lpd_link_props.sv]
// Checker for the byte link between host and command decoder
`timescale 1ns/1ps
`default_nettype none
module lpd_link_props (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic wr_stb,
   input wire logic reg_select,
   input wire logic [7:0] data,
   input wire logic iface_sel0,
   input wire logic iface_sel1,
   input wire logic busy
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   ///////////////////////////////////////////////////////////////////////
   // Busy lasts ten cycles, then drops
   sequence s_busy_run;
      busy [*8] ##1 busy [*2] ##1 !busy;
   endsequence
   // Host stays silent through busy and its own two hand-back cycles
   sequence s_quiet;
      !wr_stb [*8] ##1 !wr_stb [*4];
   endsequence
   property p_take_busy;
      wr_stb && !busy |=> busy;
   endproperty
   property p_busy_len;
      $rose(busy) |-> s_busy_run;
   endproperty
   property p_busy_cause;
      $rose(busy) |-> $past(wr_stb);
   endproperty
   property p_stb_gap;
      wr_stb |=> s_quiet;
   endproperty
   property p_no_stb_busy;
      busy |-> !wr_stb;
   endproperty
   property p_no_test;
      wr_stb && !reg_select && data[7:4] == 4'hF |-> data == 8'hF3;
   endproperty
   property p_no_pwm11;
      wr_stb && !reg_select && data[7:3] == 5'h12 |-> data[1:0] != 2'h3;
   endproperty
   property p_sel_hold;
      busy |-> $stable({iface_sel0, iface_sel1});
   endproperty
   a_take_busy: assert property (p_take_busy)
      else $error("busy did not rise after a taken byte");
   a_busy_len: assert property (p_busy_len)
      else $error("busy span is not ten cycles");
   a_busy_cause: assert property (p_busy_cause)
      else $error("busy rose without a strobe");
   a_stb_gap: assert property (p_stb_gap)
      else $error("strobes closer than the byte spacing");
   a_no_stb_busy: assert property (p_no_stb_busy)
      else $error("strobe while busy");
   a_no_test: assert property (p_no_test)
      else $error("reserved test code sent");
   a_no_pwm11: assert property (p_no_pwm11)
      else $error("illegal pulse step code sent");
   a_sel_hold: assert property (p_sel_hold)
      else $error("interface select moved during a transfer");
endmodule
`default_nettype wire

// [tb_top.sv]
// Bench joining host end and decoder end over the byte link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic i_clk_sys = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_req = 1'b0;
   logic i_reg_select = 1'b0;
   logic [7:0] i_byte = 8'h00;
   logic [1:0] i_iface_sel = 2'h1;
   logic o_ready, o_bias_save, o_common_scan_dir, o_seg_reverse, o_osc_on;
   logic o_sleep, o_soft_reset, o_frame_mod_sel, o_data_stb, o_gray_we;
   logic [1:0] o_boost_sel, o_pulse_steps;
   logic [2:0] o_resistor_ratio, o_bias_ratio, fp;
   logic [5:0] o_contrast_level, o_gray_addr, o_gray_width;
   logic [7:0] o_data, v, g, lim;
   logic [15:0] expq [$];
   int failures = 0;
   int n_compared = 0;
   int seed = 32'h1c39;
   lpd_if i_lpd_if ();
   lpd_host i_lpd_host (.i_clk_sys, .i_rst_n, .lnk(i_lpd_if), .i_req,
      .i_reg_select, .i_byte, .i_iface_sel, .o_ready);
   lpd_dev i_lpd_dev (.i_clk_sys, .i_rst_n, .lnk(i_lpd_if), .o_bias_save,
      .o_boost_sel, .o_resistor_ratio, .o_contrast_level, .o_bias_ratio,
      .o_common_scan_dir, .o_seg_reverse, .o_osc_on, .o_sleep,
      .o_soft_reset, .o_frame_mod_sel, .o_pulse_steps, .o_data_stb,
      .o_data, .o_gray_we, .o_gray_addr, .o_gray_width);
   lpd_link_props i_lpd_link_props (.i_clk_sys, .i_rst_n,
      .wr_stb(i_lpd_if.wr_stb), .reg_select(i_lpd_if.reg_select),
      .data(i_lpd_if.data), .iface_sel0(i_lpd_if.iface_sel0),
      .iface_sel1(i_lpd_if.iface_sel1), .busy(i_lpd_if.busy));
   always #5 i_clk_sys = ~i_clk_sys;
   ///////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // One byte per call; returns once the host is ready again
   task automatic send(input logic rs, input logic [7:0] b);
      int n;
      @(posedge i_clk_sys);
      i_req <= 1'b1;
      i_reg_select <= rs;
      i_byte <= b;
      @(posedge i_clk_sys);
      i_req <= 1'b0;
      n = 0;
      do begin
         @(posedge i_clk_sys);
         #1 n++;
      end while (o_ready !== 1'b1 && n < 40);
      if (n >= 40) chk(16'h0, 16'h1);
   endtask
   // Data bytes kept below 80h so none can look like a reserved code
   task automatic burst(input logic [7:0] n);
      logic [7:0] d;
      send(0, 8'hE8);
      send(0, n);
      for (int j = 0; j <= n; j++) begin
         d = 8'($random(seed)) & 8'h7F;
         expq.push_back({8'h40, d});
         send(j[0], d);
      end
   endtask
   task automatic see(input logic [15:0] s);
      if (expq.size() == 0)
         chk(s, 16'hFFFF);
      else
         chk(s, expq.pop_front());
   endtask
   ///////////////////////////////////////////////////////////////////////
   always @(posedge i_clk_sys) begin
      if (o_data_stb === 1'b1) see({8'h40, o_data});
      if (o_gray_we === 1'b1) see({2'h2, o_gray_addr, 2'h0, o_gray_width});
      if (o_soft_reset === 1'b1) see(16'hC000);
   end
   initial begin
      #200000;
      failures++;
      tally_and_finish();
   end
   initial begin
      repeat (6) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      #1 chk({o_bias_save, o_sleep, o_osc_on, o_common_scan_dir,
         o_boost_sel, o_bias_ratio, o_contrast_level}, 15'h20);
      for (int k = 0; k < 8; k++) begin
         send(0, 8'h64 | k[1:0]);
         send(0, 8'h20 | k[2:0]);
         send(0, 8'h50 | k[2:0]);
         chk(o_boost_sel, k[1:0]);
         chk(o_resistor_ratio, k[2:0]);
         chk(o_bias_ratio, k[2:0]);
      end
      v = 8'($random(seed)) & 8'h3F;
      send(0, 8'h81);
      send(0, v);
      send(0, 8'h22);
      chk({o_contrast_level, o_resistor_ratio}, {v[5:0], 3'h2});
      send(0, 8'hF3);
      send(0, 8'h00);
      chk(o_bias_save, 1'b1);
      send(0, 8'hF3);
      send(0, 8'h04);
      chk(o_bias_save, 1'b0);
      send(0, 8'hC8);
      send(0, 8'hA1);
      chk({o_common_scan_dir, o_seg_reverse}, 2'h3);
      send(0, 8'hC0);
      send(0, 8'hA0);
      chk({o_common_scan_dir, o_seg_reverse}, 2'h0);
      send(0, 8'hAB);
      send(0, 8'hA8);
      chk({o_osc_on, o_sleep}, 2'h2);
      send(0, 8'hA9);
      chk(o_sleep, 1'b1);
      send(0, 8'hE1);
      send(0, 8'hE3);
      send(0, 8'hF5);
      chk({o_sleep, o_boost_sel, o_bias_save}, 4'h6);
      send(0, 8'hC8);
      expq.push_back(16'hC000);
      send(0, 8'hE2);
      chk({o_common_scan_dir, o_boost_sel, o_contrast_level},
         {3'h3, v[5:0]});
      fp = 3'h0;
      for (int m = 0; m < 8; m++) begin
         send(0, 8'h90 | m[2:0]);
         if (m[1:0] != 2'h3) fp = m[2:0];
         chk({o_frame_mod_sel, o_pulse_steps}, fp);
         // Levels 12 to 15 keep the prefix clear of the one-byte codes
         g = {2'h2, 4'($random(seed)) | 4'hC, m[1:0]};
         lim = (fp[1:0] == 2'h2) ? 8'h3C : 8'h2D;
         expq.push_back({2'h2, g[5:0], 2'h0, m[0] ? 6'h0 : lim[5:0]});
         send(0, g);
         send(0, lim + {7'h0, m[0]});
      end
      @(posedge i_clk_sys);
      i_iface_sel <= 2'h0;
      burst(8'h00);
      burst(8'h2F);
      send(0, 8'h65);
      chk(o_boost_sel, 2'h1);
      @(posedge i_clk_sys);
      i_iface_sel <= 2'h1;
      send(0, 8'hE8);
      send(0, 8'h66);
      chk(o_boost_sel, 2'h2);
      expq.push_back(16'h4067);
      send(1, 8'h67);
      chk(o_boost_sel, 2'h2);
      repeat (3) @(posedge i_clk_sys);
      chk(expq.size(), 16'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
